// *** design/irr_top.sv ***
// internal ram debug readout: index register, ram fetch and six readout registers
// How it works
// - six read-only 64-bit readout registers exist
// - index write selects ram, loads readouts
// - only highest privilege level, else undefined
// - crm 0 instr, crm 1 data, op2 0-2
// - select code 0x00 is instruction tag
// - code 0x01 instruction data, location 13..3
// - code 0x02 branch target buffer, 14..5
// - code 0x03 global history buffer
// - code 0x04 instruction tlb, entry below 47
// - code 0x05 prediction queue, index 9..4
// - tag: non-secure bit 39, address 38..3
// - tag: set state in bits 2..1
// - data: 64 bits, then 8 bits, parity
// - btb: 82 bits over two registers
module irr_top
  import irr_pkg::*;
(
  input wire logic ref_clk,                   // core clock, 200 MHz
  input wire logic srst,                      // synchronous reset, active high
  input wire logic acc_valid,                 // one-cycle system register access strobe
  input irr_acc_t acc,                        // the access itself
  output logic ans_valid,                     // one-cycle answer strobe
  output logic ans_undef,                     // answer is an undefined-instruction fault
  output logic [63:0] ans_rdata,              // read data of the answer
  output logic ram_req,                       // ram read request, held until ram_ack
  output logic [7:0] ram_code,                // select code of the ram to read
  output logic [IRR_LOC_W-1:0] ram_loc,       // location within that ram
  input wire logic ram_ack,                   // ram has returned the entry
  input wire logic [IRR_RAW_W-1:0] ram_data   // raw entry, valid with ram_ack
);

  // decoded fields of an index value
  typedef struct packed {
    logic fetch;                              // a real ram read is needed
    logic [IRR_LOC_W-1:0] loc;                // location sent to the ram
  } irr_loc_t;

  // location decode of an index; used for the request and the checks
  function automatic irr_loc_t loc_of(input logic [31:0] idx);
    irr_loc_t r;
    r.fetch = 1'b1;
    r.loc = '0;
    unique case (idx[IRR_SEL_HI:IRR_SEL_LO])
      IRR_RAM_ITAG: r.loc = {1'b0, idx[19:18], idx[13:6]};
      IRR_RAM_IDATA: r.loc = idx[13:3];
      IRR_RAM_BTB: r.loc = {1'b0, idx[14:5]};
      IRR_RAM_GHB: r.loc = {1'b0, idx[13:4]};
      IRR_RAM_ITLB: begin
        r.loc = {3'h0, idx[7:0]};
        // out-of-range entries never reach the tlb array
        r.fetch = (idx[7:0] < IRR_TLB_LIMIT);
      end
      IRR_RAM_BPQ: r.loc = {5'h00, idx[9:4]};
      default: r.fetch = 1'b0;
    endcase
    return r;
  endfunction : loc_of

  // access classification, all on the same clock as the pipeline
  logic space_hit;                            // op1 and CRn belong to this block
  logic priv_ok;                              // issued at the highest level
  logic is_index_wr;                          // legal index write encoding
  logic is_rd;                                // legal readout read encoding
  logic acc_ok;                               // access accepted
  logic acc_bad;                              // access faults
  irr_loc_t wr_loc;                           // decode of the incoming index
  irr_loc_t idx_loc;                          // decode of the stored index, read by the checks
  irr_state_t state;                          // fill sequencer state
  logic [31:0] index;                         // ram select index register
  irr_words_t iwords;                         // instruction readout registers
  irr_words_t dwords;                         // data readout registers
  irr_words_t fmt_words;                      // formatter output
  logic [63:0] rd_word;                       // selected readout word

  // decode of the system instruction fields
  always_comb begin
    space_hit = (acc.op1 == IRR_OP1) && (acc.crn == IRR_CRN);
    priv_ok = (acc.el == IRR_EL_TOP);
    is_index_wr = acc.write && (acc.crm == IRR_CRM_INSTR) && (acc.op2 == IRR_OP2_R0);
    is_rd = !acc.write && ((acc.crm == IRR_CRM_INSTR) || (acc.crm == IRR_CRM_DATA)) &&
            (acc.op2 <= IRR_OP2_R2);
    acc_ok = acc_valid && space_hit && priv_ok && (is_index_wr || is_rd) &&
             (state == IRR_S_IDLE);
    // wrong level or an encoding this block does not own is refused
    acc_bad = acc_valid && (state == IRR_S_IDLE) && !(space_hit && priv_ok && (is_index_wr || is_rd));
    wr_loc = loc_of(acc.wdata[31:0]);
    // the stored index decoded again, so the request can be held against it
    idx_loc = loc_of(index);
  end

  // readout word selection for a read
  always_comb begin
    rd_word = IRR_WORD_RST;
    unique case ({acc.crm == IRR_CRM_DATA, acc.op2})
      {1'b0, IRR_OP2_R0}: rd_word = iwords.w0;
      {1'b0, IRR_OP2_R1}: rd_word = iwords.w1;
      {1'b0, IRR_OP2_R2}: rd_word = iwords.w2;
      {1'b1, IRR_OP2_R0}: rd_word = dwords.w0;
      {1'b1, IRR_OP2_R1}: rd_word = dwords.w1;
      {1'b1, IRR_OP2_R2}: rd_word = dwords.w2;
      default: rd_word = IRR_WORD_RST;
    endcase
  end

  // entry layout for the selected ram
  irr_fmt u_fmt (
    .sel_code(ram_code),
    .raw(ram_data),
    .words(fmt_words)
  );

  // index register: write-only for software, kept for the fetch
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      index <= IRR_INDEX_RST;
    end else if (acc_ok && is_index_wr) begin
      index <= acc.wdata[31:0];
    end
  end

  // fill sequencer: a write is answered only after the readouts hold the new entry,
  // so any later read already sees it, with or without a barrier in between
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= IRR_S_IDLE;
    end else begin
      unique case (state)
        IRR_S_IDLE: begin
          if (acc_ok && is_index_wr) begin
            // no ram read for reserved codes or bad tlb entries
            state <= wr_loc.fetch ? IRR_S_WAIT : IRR_S_ANS;
          end
        end
        IRR_S_WAIT: begin
          if (ram_ack) begin
            state <= IRR_S_ANS;
          end
        end
        IRR_S_ANS: begin
          state <= IRR_S_IDLE;
        end
        default: begin
          state <= IRR_S_IDLE;
        end
      endcase
    end
  end

  // ram read request, held until the ram acknowledges
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ram_req <= 1'b0;
      ram_code <= IRR_RAM_ITAG;
      ram_loc <= '0;
    end else if (acc_ok && is_index_wr) begin
      ram_req <= wr_loc.fetch;
      ram_code <= acc.wdata[IRR_SEL_HI:IRR_SEL_LO];
      ram_loc <= wr_loc.loc;
    end else if (ram_ack) begin
      ram_req <= 1'b0;
    end
  end

  // instruction readouts: loaded from the ram, zeroed when nothing is fetched
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      iwords <= '{w2: IRR_WORD_RST, w1: IRR_WORD_RST, w0: IRR_WORD_RST};
    end else if (state == IRR_S_WAIT && ram_ack) begin
      iwords <= fmt_words;
    end else if (acc_ok && is_index_wr && !wr_loc.fetch) begin
      // stale content must not pass for the new selection
      iwords <= '{w2: IRR_WORD_RST, w1: IRR_WORD_RST, w0: IRR_WORD_RST};
    end
  end

  // data readouts: none of the rams here use them, they read as zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dwords <= '{w2: IRR_WORD_RST, w1: IRR_WORD_RST, w0: IRR_WORD_RST};
    end else if (acc_ok && is_index_wr) begin
      dwords <= '{w2: IRR_WORD_RST, w1: IRR_WORD_RST, w0: IRR_WORD_RST};
    end
  end

  // answer port: reads answer next cycle, writes after the fill, faults next cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ans_valid <= 1'b0;
      ans_undef <= 1'b0;
      ans_rdata <= IRR_WORD_RST;
    end else if (acc_bad) begin
      // refused access answers with the fault flag and no data
      ans_valid <= 1'b1;
      ans_undef <= 1'b1;
      ans_rdata <= IRR_WORD_RST;
    end else if (acc_ok && is_rd) begin
      // reads answer from the registers, never from the ram
      ans_valid <= 1'b1;
      ans_undef <= 1'b0;
      ans_rdata <= rd_word;
    end else if (state == IRR_S_ANS) begin
      // the write is answered once the readouts hold the entry
      ans_valid <= 1'b1;
      ans_undef <= 1'b0;
      ans_rdata <= IRR_WORD_RST;
    end else begin
      // strobe and data drop back to zero between answers
      ans_valid <= 1'b0;
      ans_undef <= 1'b0;
      ans_rdata <= IRR_WORD_RST;
    end
  end

  // a wrong level always faults one cycle later while the sequencer is idle
  a_undef_low_level: assert property (@(posedge ref_clk) disable iff (srst)
    acc_valid && state == IRR_S_IDLE && acc.el != IRR_EL_TOP |=> ans_valid && ans_undef)
    else $error("access below top level did not fault");

  // a legal index write to a fetchable ram starts a request
  a_write_fetches: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_index_wr && wr_loc.fetch |=> ram_req && ram_code == $past(acc.wdata[31:24]))
    else $error("index write did not request the ram");

  // out-of-range tlb entries never reach the ram
  a_tlb_range: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_index_wr && acc.wdata[31:24] == IRR_RAM_ITLB && acc.wdata[7:0] >= 8'h2f
    |=> !ram_req ##1 ans_valid && iwords.w0 == 64'h0000_0000_0000_0000)
    else $error("tlb entry 47 or above was fetched");

  // the request holds until acknowledged
  a_req_holds: assert property (@(posedge ref_clk) disable iff (srst)
    ram_req && !ram_ack |=> ram_req)
    else $error("ram request dropped early");

  // write answer follows the load, two cycles after the acknowledge
  a_write_answer: assert property (@(posedge ref_clk) disable iff (srst)
    state == IRR_S_WAIT && ram_ack |=> !ans_valid ##1 ans_valid && !ans_undef)
    else $error("write answer not after the fill");

  // tag layout: bit 0, upper bits and registers 1, 2 are zero
  a_tag_layout: assert property (@(posedge ref_clk) disable iff (srst)
    state == IRR_S_WAIT && ram_ack && ram_code == IRR_RAM_ITAG
    |=> iwords.w0[63:40] == 24'h00_0000 && iwords.w0[0] == 1'b0 && iwords.w1 == 64'h0 &&
        iwords.w2 == 64'h0 && iwords.w0[39:1] == $past(ram_data[38:0]))
    else $error("tag entry misplaced");

  // instruction data: parity at bit 8 of register 1, rest zero
  a_idata_layout: assert property (@(posedge ref_clk) disable iff (srst)
    state == IRR_S_WAIT && ram_ack && ram_code == IRR_RAM_IDATA
    |=> iwords.w1[63:9] == 55'h0 && iwords.w1[8:0] == $past(ram_data[72:64]) && iwords.w2 == 64'h0)
    else $error("instruction data entry misplaced");

  // btb: 18 bits in register 1, register 2 zero
  a_btb_layout: assert property (@(posedge ref_clk) disable iff (srst)
    state == IRR_S_WAIT && ram_ack && ram_code == IRR_RAM_BTB
    |=> iwords.w1[63:18] == 46'h0 && iwords.w1[17:0] == $past(ram_data[81:64]) && iwords.w2 == 64'h0)
    else $error("btb entry misplaced");

  // a read of instruction readout 0 answers next cycle with that register
  a_read_answer: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_rd && acc.crm == IRR_CRM_INSTR && acc.op2 == IRR_OP2_R0
    |=> ans_valid && !ans_undef && ans_rdata == iwords.w0)
    else $error("instruction readout 0 read wrong");

  // a read of any data readout answers zero for every ram served here
  a_data_zero: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_rd && acc.crm == IRR_CRM_DATA |=> ans_valid && !ans_undef && ans_rdata == 64'h0)
    else $error("data readout not zero");

  // while the ram is asked, code and location still follow the stored index
  a_index_match: assert property (@(posedge ref_clk) disable iff (srst)
    ram_req |-> idx_loc.fetch && ram_code == index[IRR_SEL_HI:IRR_SEL_LO] && ram_loc == idx_loc.loc)
    else $error("ram request differs from the index");

  // instruction readout 1 answers its own register
  a_read_instr_one: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_rd && acc.crm == IRR_CRM_INSTR && acc.op2 == IRR_OP2_R1 |=> ans_rdata == iwords.w1)
    else $error("instruction readout 1 read wrong");

  // instruction readout 2 answers its own register
  a_read_instr_two: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_rd && acc.crm == IRR_CRM_INSTR && acc.op2 == IRR_OP2_R2 |=> ans_rdata == iwords.w2)
    else $error("instruction readout 2 read wrong");

  // op2 above 2 names no register here, whatever else the access holds
  a_op2_range: assert property (@(posedge ref_clk) disable iff (srst)
    acc_valid && state == IRR_S_IDLE && acc.op2 > IRR_OP2_R2 |=> ans_valid && ans_undef)
    else $error("op2 above 2 did not fault");

  // readouts are read-only: a write to the data side faults
  a_readout_write: assert property (@(posedge ref_clk) disable iff (srst)
    acc_valid && state == IRR_S_IDLE && acc.write && acc.crm == IRR_CRM_DATA |=> ans_valid && ans_undef)
    else $error("write to a readout did not fault");

  // a reserved select code fetches nothing and answers with cleared readouts
  a_reserved_code: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_index_wr && acc.wdata[31:24] > IRR_RAM_BPQ
    |=> !ram_req ##1 ans_valid && !ans_undef && iwords == '0)
    else $error("reserved code not answered empty");

  // instruction data location is index bits 13..3 as they stand
  a_idata_loc: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_index_wr && acc.wdata[31:24] == IRR_RAM_IDATA
    |=> ram_req && ram_loc == $past(acc.wdata[13:3]))
    else $error("instruction data location wrong");

  // btb location is index bits 14..5
  a_btb_loc: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_index_wr && acc.wdata[31:24] == IRR_RAM_BTB
    |=> ram_req && ram_loc == {1'b0, $past(acc.wdata[14:5])})
    else $error("btb location wrong");

  // a tlb entry below the limit is fetched at that entry
  a_tlb_loc: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_index_wr && acc.wdata[31:24] == IRR_RAM_ITLB && acc.wdata[7:0] < IRR_TLB_LIMIT
    |=> ram_req && ram_loc == {3'h0, $past(acc.wdata[7:0])})
    else $error("tlb location wrong");

  // prediction queue location is index bits 9..4
  a_bpq_loc: assert property (@(posedge ref_clk) disable iff (srst)
    acc_ok && is_index_wr && acc.wdata[31:24] == IRR_RAM_BPQ
    |=> ram_req && ram_loc == {5'h00, $past(acc.wdata[9:4])})
    else $error("prediction queue location wrong");

  // ghb entries use the btb layout
  a_ghb_layout: assert property (@(posedge ref_clk) disable iff (srst)
    state == IRR_S_WAIT && ram_ack && ram_code == IRR_RAM_GHB
    |=> iwords.w1 == {46'h0, $past(ram_data[81:64])} && iwords.w0 == $past(ram_data[63:0]) &&
        iwords.w2 == 64'h0)
    else $error("ghb entry misplaced");

  // tlb entries spread over all three readouts
  a_tlb_layout: assert property (@(posedge ref_clk) disable iff (srst)
    state == IRR_S_WAIT && ram_ack && ram_code == IRR_RAM_ITLB
    |=> iwords.w1 == $past(ram_data[127:64]) && iwords.w2 == {59'h0, $past(ram_data[132:128])})
    else $error("tlb entry misplaced");

  // prediction queue entries leave readout 1 empty
  a_bpq_layout: assert property (@(posedge ref_clk) disable iff (srst)
    state == IRR_S_WAIT && ram_ack && ram_code == IRR_RAM_BPQ
    |=> iwords.w1 == 64'h0 && iwords.w2 == {32'h0, $past(ram_data[95:64])})
    else $error("prediction queue entry misplaced");

  // between answers the port shows nothing, so a stale word cannot pass
  a_ans_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    !ans_valid |-> !ans_undef && ans_rdata == 64'h0)
    else $error("answer fields set without the strobe");

endmodule : irr_top

// *** shared/irr_pkg.sv ***
// constants, codes and carriers for the internal ram debug readout block
package irr_pkg;

  // privilege and system instruction encoding of this register space
  localparam logic [1:0] IRR_EL_TOP = 2'h3;          // highest privilege level
  localparam logic [2:0] IRR_OP1 = 3'h6;             // op1 of every access
  localparam logic [3:0] IRR_CRN = 4'hf;             // CRn of every access
  localparam logic [3:0] IRR_CRM_INSTR = 4'h0;       // instruction readouts and index write
  localparam logic [3:0] IRR_CRM_DATA = 4'h1;        // data readouts
  localparam logic [2:0] IRR_OP2_R0 = 3'h0;          // readout 0, also the index write
  localparam logic [2:0] IRR_OP2_R1 = 3'h1;          // readout 1
  localparam logic [2:0] IRR_OP2_R2 = 3'h2;          // readout 2

  // ram select codes, index bits 31..24
  localparam int IRR_SEL_HI = 31;                    // top bit of the select code
  localparam int IRR_SEL_LO = 24;                    // bottom bit of the select code
  localparam logic [7:0] IRR_RAM_ITAG = 8'h00;       // instruction cache tag
  localparam logic [7:0] IRR_RAM_IDATA = 8'h01;      // instruction cache data
  localparam logic [7:0] IRR_RAM_BTB = 8'h02;        // branch target buffer
  localparam logic [7:0] IRR_RAM_GHB = 8'h03;        // global history buffer
  localparam logic [7:0] IRR_RAM_ITLB = 8'h04;       // instruction tlb
  localparam logic [7:0] IRR_RAM_BPQ = 8'h05;        // branch prediction queue
  localparam logic [7:0] IRR_TLB_LIMIT = 8'h2f;      // tlb entries must be below 47

  // widths and reset values
  localparam int IRR_LOC_W = 11;                     // widest location field
  localparam int IRR_RAW_W = 136;                    // widest raw ram entry
  localparam logic [31:0] IRR_INDEX_RST = 32'h0000_0000;  // index after reset
  localparam logic [63:0] IRR_WORD_RST = 64'h0000_0000_0000_0000;  // readouts after reset

  // states of the fill sequencer, gray along idle -> wait -> answer
  typedef enum logic [1:0] {
    IRR_S_IDLE = 2'b00,
    IRR_S_WAIT = 2'b01,
    IRR_S_ANS = 2'b11
  } irr_state_t;

  // one system register access from the pipeline
  typedef struct packed {
    logic write;           // 1 write, 0 read
    logic [1:0] el;        // exception level of the access
    logic [2:0] op1;       // op1 field
    logic [3:0] crn;       // CRn field
    logic [3:0] crm;       // CRm field
    logic [2:0] op2;       // op2 field
    logic [63:0] wdata;    // write data
  } irr_acc_t;

  // the three readout words of one entry
  typedef struct packed {
    logic [63:0] w2;       // readout 2
    logic [63:0] w1;       // readout 1
    logic [63:0] w0;       // readout 0
  } irr_words_t;

endpackage : irr_pkg

// *** design/irr_fmt.sv ***
// places one raw ram entry into the three instruction readout words
module irr_fmt
  import irr_pkg::*;
(
  input wire logic [7:0] sel_code,            // ram select code of the entry
  input wire logic [IRR_RAW_W-1:0] raw,       // raw entry as the ram returns it
  output irr_words_t words                    // formatted readout words
);

  // per-ram layout; unlisted bits stay zero
  always_comb begin
    words = '{w2: IRR_WORD_RST, w1: IRR_WORD_RST, w0: IRR_WORD_RST};
    unique case (sel_code)
      IRR_RAM_ITAG: begin
        // non-secure at 39, pa 47..12 at 38..3, set state at 2..1
        words.w0 = {24'h00_0000, raw[38:0], 1'b0};
      end
      IRR_RAM_IDATA: begin
        words.w0 = raw[63:0];
        words.w1 = {55'h0, raw[72:64]};
      end
      IRR_RAM_BTB, IRR_RAM_GHB: begin
        words.w0 = raw[63:0];
        words.w1 = {46'h0, raw[81:64]};
      end
      IRR_RAM_ITLB: begin
        words.w0 = raw[63:0];
        words.w1 = raw[127:64];
        words.w2 = {59'h0, raw[132:128]};
      end
      IRR_RAM_BPQ: begin
        words.w0 = raw[63:0];
        words.w2 = {32'h0000_0000, raw[95:64]};
      end
      default: begin
        // reserved select codes read back as zero
        words.w0 = IRR_WORD_RST;
      end
    endcase
  end

endmodule : irr_fmt

// *** tb/irr_tb.sv ***
// self-checking bench for the internal ram debug readout block
module tb
  import irr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0; // core clock, 200 MHz
  logic srst; // synchronous reset
  logic acc_valid; // access strobe
  irr_acc_t acc; // access fields
  logic ans_valid; // answer strobe from the block
  logic ans_undef; // fault flag from the block
  logic [63:0] ans_rdata; // read data from the block
  logic ram_req; // ram request from the block
  logic [7:0] ram_code; // requested ram
  logic [IRR_LOC_W-1:0] ram_loc; // requested location
  logic ram_ack; // bench stands in for the rams
  logic [IRR_RAW_W-1:0] ram_data; // raw entry handed back
  int err_count; // mismatches
  int compares; // comparisons made
  logic [31:0] seed; // lfsr state
  logic got_undef; // captured answer fields
  logic [63:0] got_data;
  logic got_req; // a ram fetch was seen
  logic [7:0] got_code;
  logic [IRR_LOC_W-1:0] got_loc;
  int got_lat; // cycles from take to answer, minus one

  irr_top i_dut (
    .ref_clk(ref_clk),
    .srst(srst),
    .acc_valid(acc_valid),
    .acc(acc),
    .ans_valid(ans_valid),
    .ans_undef(ans_undef),
    .ans_rdata(ans_rdata),
    .ram_req(ram_req),
    .ram_code(ram_code),
    .ram_loc(ram_loc),
    .ram_ack(ram_ack),
    .ram_data(ram_data)
  );

  // free-running clock, half period 2.5 ns
  always #2.5 ref_clk = ~ref_clk;

  // maximal-length lfsr, so the run repeats exactly
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // builds one system register access
  function automatic irr_acc_t mk(logic w, logic [1:0] e, logic [2:0] o1, logic [3:0] cn, logic [3:0] cm,
                                  logic [2:0] o2, logic [63:0] d);
    return '{w, e, o1, cn, cm, o2, d};
  endfunction : mk

  // expected instruction readouts for one raw entry
  function automatic irr_words_t exp_words(logic [7:0] c, logic [IRR_RAW_W-1:0] r);
    irr_words_t w;
    w = '0;
    w.w0 = (c == IRR_RAM_ITAG) ? 64'(r[38:0]) << 1 : r[63:0];
    case (c)
      IRR_RAM_IDATA: w.w1 = 64'(r[72:64]);
      IRR_RAM_BTB, IRR_RAM_GHB: w.w1 = 64'(r[81:64]);
      IRR_RAM_ITLB: begin
        w.w1 = r[127:64];
        w.w2 = 64'(r[132:128]);
      end
      IRR_RAM_BPQ: w.w2 = 64'(r[95:64]);
      default: ;
    endcase
    return w;
  endfunction : exp_words

  // expected location field sent to the ram
  function automatic logic [IRR_LOC_W-1:0] exp_loc(logic [7:0] c, logic [31:0] i);
    case (c)
      IRR_RAM_ITAG: return 11'({i[19:18], i[13:6]});
      IRR_RAM_IDATA: return i[13:3];
      IRR_RAM_BTB: return 11'(i[14:5]);
      IRR_RAM_GHB: return 11'(i[13:4]);
      IRR_RAM_ITLB: return 11'(i[7:0]);
      default: return 11'(i[9:4]);
    endcase
  endfunction : exp_loc

  // counts and reports one comparison
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // single closing point of the run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // one access; answers a ram fetch after a random stall
  task automatic do_acc(input irr_acc_t a, input logic [IRR_RAW_W-1:0] raw);
    logic ack_now;
    logic acked;
    int n;
    acked = 1'b0;
    got_req = 1'b0;
    @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc <= a;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    acc <= ~a; // stale fields scrambled so a late sample shows
    for (n = 0; n < 200; n++) begin
      #1;
      if (ans_valid === 1'b1) break;
      if (ram_req === 1'b1 && !got_req) begin
        got_req = 1'b1;
        got_code = ram_code;
        got_loc = ram_loc;
      end
      ack_now = ram_req === 1'b1 && !acked && (rnd() % 4 == 0);
      acked = acked | ack_now;
      @(posedge ref_clk);
      ram_ack <= ack_now;
      ram_data <= ack_now ? raw : ~raw; // inverse outside the valid cycle
    end
    if (n == 200) begin
      err_count++;
      $display("Error answer wait expected ans_valid seen timeout");
      stop_test();
    end
    got_lat = n;
    got_undef = ans_undef;
    got_data = ans_rdata;
  endtask : do_acc

  // reads one readout register and compares it
  task automatic rd(input logic [3:0] cm, input logic [2:0] o2, input logic [63:0] exp, input string nm);
    do_acc(mk(1'b0, IRR_EL_TOP, IRR_OP1, IRR_CRN, cm, o2, 64'(rnd())), '0);
    chk("read latency", 64'(got_lat), '0);
    chk(nm, got_data, exp);
  endtask : rd

  // main sequence
  initial begin
    logic [7:0] code;
    logic [31:0] idx;
    logic [IRR_RAW_W-1:0] raw;
    logic fetch;
    logic [2:0][63:0] ew;
    irr_acc_t a;
    srst = 1'b1;
    acc_valid = 1'b0;
    acc = '0;
    ram_ack = 1'b0;
    ram_data = '0;
    err_count = 0;
    compares = 0;
    seed = 32'h0000_bde4;
    ew = '0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    // all six readouts come out of reset as zero
    for (int j = 0; j < 6; j++) rd(4'(j / 3), 3'(j % 3), '0, "reset readout");
    $display("test reset done");
    // every select code four times, then reserved codes; tlb entries 46 and 47 among them
    for (int k = 0; k < 27; k++) begin
      code = (k < 24) ? 8'(k % 6) : 8'(6 + (k % 3) * 60);
      idx = {code, 24'(rnd())};
      if (code == IRR_RAM_ITLB) idx[7:0] = (k == 4) ? 8'h2e : (k == 10) ? 8'h2f : 8'(rnd() % 47);
      raw = {rnd(), rnd(), rnd(), rnd(), 8'(rnd())};
      if (code == IRR_RAM_ITAG) raw[1:0] = 2'(k / 6); // every set state code in turn
      fetch = code <= IRR_RAM_BPQ && !(code == IRR_RAM_ITLB && idx[7:0] >= IRR_TLB_LIMIT);
      ew = fetch ? exp_words(code, raw) : '0;
      do_acc(mk(1'b1, IRR_EL_TOP, IRR_OP1, IRR_CRN, IRR_CRM_INSTR, IRR_OP2_R0, {32'(rnd()), idx}), raw);
      chk("write fault", 64'(got_undef), '0);
      chk("fetch made", 64'(got_req), 64'(fetch));
      if (fetch) chk("ram code", 64'(got_code), 64'(code));
      if (fetch) chk("ram location", 64'(got_loc), 64'(exp_loc(code, idx)));
      if (!fetch) chk("write latency", 64'(got_lat), 64'h1);
      for (int j = 0; j < 6; j++) rd(4'(j / 3), 3'(j % 3), (j < 3) ? ew[j] : '0, "readout");
    end
    $display("test ram selects done");
    // refused accesses: low levels, wrong encodings, writes to readouts
    for (int k = 0; k < 10; k++) begin
      a = mk(1'b0, IRR_EL_TOP, IRR_OP1, IRR_CRN, IRR_CRM_INSTR, IRR_OP2_R1, 64'(rnd()));
      case (k)
        0, 1, 2: a.el = 2'(k);
        3: begin
          a.el = 2'h1;
          a.write = 1'b1;
        end
        4: a.op1 = 3'h5;
        5: a.crn = 4'he;
        6: a.crm = 4'h2;
        7: a.op2 = 3'h3;
        8: begin
          a.crm = IRR_CRM_DATA;
          a.op2 = IRR_OP2_R0;
          a.write = 1'b1;
        end
        default: a.write = 1'b1;
      endcase
      do_acc(a, '0);
      chk("fault flag", 64'(got_undef), 64'h1);
      chk("fault data", got_data, '0);
      chk("fault fetch", 64'(got_req), '0);
    end
    rd(IRR_CRM_INSTR, IRR_OP2_R0, ew[0], "readout after faults");
    $display("test refusals done");
    // mid-run reset right after a btb load: every readout must drop back to zero
    ew = exp_words(IRR_RAM_BTB, raw);
    do_acc(mk(1'b1, IRR_EL_TOP, IRR_OP1, IRR_CRN, IRR_CRM_INSTR, IRR_OP2_R0, {32'(rnd()), IRR_RAM_BTB, 24'(rnd())}), raw);
    rd(IRR_CRM_INSTR, IRR_OP2_R1, ew[1], "readout before reset");
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    for (int j = 0; j < 6; j++) rd(4'(j / 3), 3'(j % 3), '0, "readout after reset");
    $display("test mid-run reset done");
    stop_test();
  end

endmodule : tb
